// ### hdl/asp_port.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "asp_map.svh"
// What this block does
// R1: Separate transmit and receive modules, independently configured.
// R2: Hardware places left and right channels.
// R3: Programmable FIFO trigger level per direction.
// R4: Software reads both FIFO levels.
// R5: Four interrupt sources, errors and service.
// R6: Each interrupt source has its own enable.
// R7: Enabled pending sources share one interrupt.
// R8: Raw and masked interrupt status views.
// R9: Software clears selected pending sources.
// R10: Bit and word clocks derived from master.
// R11: Master clock from internal or pin.
// R12: Configure, enable, later disable each module.
// R13: Standard, left-justified and right-justified alignment.
// R14: Clock master or clock slave role.
// R15: Separate sample size and wire size.
// R16: Mono and stereo operation.
// R17: Level counts pairs as two, odd=mismatch.
// R18: Compact modes pack left low, right high.
// R19: Dual mode reads alternate, left first.
// R20: Disabled receiver captures no serial data.
// R21: Errors on receive overrun, transmit underrun.
// R22: Service request tracks level, drives DMA.
module asp_port (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic MCLK_EXT_I,
  input wire logic TX_SCLK_I,
  output logic TX_SCLK_O,
  output logic TX_SCLK_OE_O,
  input wire logic TX_WS_I,
  output logic TX_WS_O,
  output logic TX_WS_OE_O,
  output logic TX_SD_O,
  input wire logic RX_SCLK_I,
  output logic RX_SCLK_O,
  output logic RX_SCLK_OE_O,
  input wire logic RX_WS_I,
  output logic RX_WS_O,
  output logic RX_WS_OE_O,
  input wire logic RX_SD_I,
  output logic IRQ_O,
  output logic TX_DMA_REQ_O,
  output logic RX_DMA_REQ_O
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [5:0] size_of(input logic [2:0] code);
    unique case (code)
      3'h0: size_of = 6'h08;
      3'h1: size_of = 6'h10;
      3'h2: size_of = 6'h14;
      3'h3: size_of = 6'h18;
      default: size_of = 6'h20;
    endcase
  endfunction

  function automatic logic [5:0] eff_size(input asp_pkg::asp_mode_t m,
                                          input logic [2:0] code);
    unique case (m)
      asp_pkg::MODE_C16: eff_size = 6'h10;
      asp_pkg::MODE_C8: eff_size = 6'h08;
      default: eff_size = size_of(code);
    endcase
  endfunction

  // Samples travel MSB first, so they are kept left aligned on the wire.
  function automatic logic [31:0] align(input logic [31:0] v, input logic [5:0] n);
    align = v << (`ASP_SLOT - n);
  endfunction

  function automatic logic [31:0] unalign(input logic [31:0] v, input logic [5:0] n);
    unalign = v >> (`ASP_SLOT - n);
  endfunction

  function automatic logic is_left(input asp_pkg::asp_fmt_t f, input logic ws);
    is_left = (f == asp_pkg::FMT_STD) ? !ws : ws;
  endfunction

  // Bit index within the channel word; 6'h3F or any value >= w is idle.
  function automatic logic [5:0] pos_of(input logic [4:0] cnt,
                                        input asp_pkg::asp_fmt_t f,
                                        input logic [5:0] w);
    logic [5:0] off;
    logic [5:0] c;
    c = {1'b0, cnt};
    unique case (f)
      asp_pkg::FMT_STD: off = 6'h01;
      asp_pkg::FMT_LJ: off = 6'h00;
      default: off = `ASP_SLOT - w;
    endcase
    if (f == asp_pkg::FMT_STD && cnt == 5'h00) begin
      pos_of = 6'h1F;
    end else if (c >= off && (c - off) < w) begin
      pos_of = c - off;
    end else begin
      pos_of = 6'h3F;
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [31:0] tx_cfg;
  logic [31:0] rx_cfg;
  logic [4:0] tx_lim;
  logic [4:0] rx_lim;
  logic [3:0] int_en;
  logic [3:0] raw;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [31:0] rd_data;
  logic tx_en;
  logic rx_en;
  asp_pkg::asp_fmt_t tx_fmt;
  asp_pkg::asp_fmt_t rx_fmt;
  asp_pkg::asp_mode_t tx_mode;
  asp_pkg::asp_mode_t rx_mode;
  logic [5:0] tx_ss;
  logic [5:0] rx_ss;
  logic [5:0] tx_w;
  logic [5:0] rx_w;

  assign access = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_acc = access && PWRITE_I;
  assign rd_acc = access && !PWRITE_I;
  assign tx_en = ctrl[`ASP_TX_EN]; // R12
  assign rx_en = ctrl[`ASP_RX_EN]; // R12
  assign tx_fmt = asp_pkg::asp_fmt_t'(tx_cfg[`ASP_CF_FMT]); // R1
  assign rx_fmt = asp_pkg::asp_fmt_t'(rx_cfg[`ASP_CF_FMT]); // R1
  assign tx_mode = asp_pkg::asp_mode_t'(tx_cfg[`ASP_CF_MODE]);
  assign rx_mode = asp_pkg::asp_mode_t'(rx_cfg[`ASP_CF_MODE]);
  assign tx_ss = eff_size(tx_mode, tx_cfg[`ASP_CF_SSZ]); // R15
  assign rx_ss = eff_size(rx_mode, rx_cfg[`ASP_CF_SSZ]); // R15
  assign tx_w = size_of(tx_cfg[`ASP_CF_WSZ]); // R15
  assign rx_w = size_of(rx_cfg[`ASP_CF_WSZ]); // R15

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ctrl <= 4'h0;
      tx_cfg <= `ASP_CFG_RST;
      rx_cfg <= `ASP_CFG_RST;
      tx_lim <= `ASP_LIM_RST;
      rx_lim <= `ASP_LIM_RST;
      int_en <= 4'h0;
    end else if (wr_acc) begin
      case (PADDR_I)
        `ASP_CTRL: ctrl <= PWDATA_I[3:0]; // R12
        `ASP_TXCFG: tx_cfg <= PWDATA_I & `ASP_CFG_MASK;
        `ASP_RXCFG: rx_cfg <= PWDATA_I & `ASP_CFG_MASK;
        `ASP_TXLIM: tx_lim <= PWDATA_I[4:0]; // R3
        `ASP_RXLIM: rx_lim <= PWDATA_I[4:0]; // R3
        `ASP_INTEN: int_en <= PWDATA_I[3:0]; // R6
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Master clock source and serial timing
  // --------------------------------------------------------------------
  logic [2:0] mclk_sy;
  logic mclk_st;
  logic mclk_edge;
  logic tx_rise;
  logic tx_fall;
  logic rx_rise;
  logic rx_fall;
  logic tx_rose;
  logic rx_rose;
  logic [4:0] tx_cnt_s;
  logic [4:0] rx_cnt_s;
  logic tx_ws_cur;
  logic rx_ws_cur;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      mclk_sy <= 3'h0;
      mclk_st <= 1'b0;
    end else begin
      mclk_sy <= {mclk_sy[1:0], MCLK_EXT_I};
      if (mclk_sy[1] == mclk_sy[2]) begin
        mclk_st <= mclk_sy[2];
      end
    end
  end
  assign mclk_edge = (mclk_sy[1] == mclk_sy[2]) && mclk_sy[2] && !mclk_st;

  asp_timing u_tx (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(tx_en),
    .master_i(tx_cfg[`ASP_CF_MST]),
    .tick_i(ctrl[`ASP_TX_MEXT] ? mclk_edge : 1'b1), // R11
    .div_i(tx_cfg[`ASP_CF_DIV]),
    .sclk_pin_i(TX_SCLK_I),
    .ws_pin_i(TX_WS_I),
    .sclk_o(TX_SCLK_O),
    .ws_o(TX_WS_O),
    .rise_o(tx_rise),
    .fall_o(tx_fall),
    .cnt_o(tx_cnt_s),
    .ws_cur_o(tx_ws_cur)
  );

  asp_timing u_rx (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(rx_en),
    .master_i(rx_cfg[`ASP_CF_MST]),
    .tick_i(ctrl[`ASP_RX_MEXT] ? mclk_edge : 1'b1), // R11
    .div_i(rx_cfg[`ASP_CF_DIV]),
    .sclk_pin_i(RX_SCLK_I),
    .ws_pin_i(RX_WS_I),
    .sclk_o(RX_SCLK_O),
    .ws_o(RX_WS_O),
    .rise_o(rx_rise),
    .fall_o(rx_fall),
    .cnt_o(rx_cnt_s),
    .ws_cur_o(rx_ws_cur)
  );

  // Slot counters settle one cycle after the edge, so work on that cycle.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      tx_rose <= 1'b0;
      rx_rose <= 1'b0;
      TX_SCLK_OE_O <= 1'b0;
      TX_WS_OE_O <= 1'b0;
      RX_SCLK_OE_O <= 1'b0;
      RX_WS_OE_O <= 1'b0;
    end else begin
      tx_rose <= tx_rise;
      rx_rose <= rx_rise;
      TX_SCLK_OE_O <= tx_en && tx_cfg[`ASP_CF_MST]; // R14
      TX_WS_OE_O <= tx_en && tx_cfg[`ASP_CF_MST]; // R14
      RX_SCLK_OE_O <= rx_en && rx_cfg[`ASP_CF_MST]; // R14
      RX_WS_OE_O <= rx_en && rx_cfg[`ASP_CF_MST]; // R14
    end
  end

  // --------------------------------------------------------------------
  // Transmit FIFO and serialiser
  // --------------------------------------------------------------------
  logic [63:0] tx_mem [`ASP_PAIRS];
  logic [2:0] tx_wp;
  logic [2:0] tx_rp;
  logic [3:0] tx_cnt;
  logic tx_half;
  logic [31:0] tx_hold;
  logic [63:0] tx_pair;
  logic tx_wr;
  logic tx_push;
  logic tx_pop_req;
  logic tx_pop;
  logic [4:0] tx_lvl;
  logic [31:0] tx_l;
  logic [31:0] tx_r;
  logic [31:0] tx_pend;
  logic [4:0] tx_nc;
  logic tx_nleft;
  logic [5:0] tx_p;
  logic [31:0] tx_word;

  always_comb begin
    unique case (tx_mode) // R18
      asp_pkg::MODE_DUAL: tx_pair = {PWDATA_I, tx_hold};
      asp_pkg::MODE_C16: tx_pair = {16'h0000, PWDATA_I[31:16], 16'h0000, PWDATA_I[15:0]};
      asp_pkg::MODE_C8: tx_pair = {24'h000000, PWDATA_I[15:8], 24'h000000, PWDATA_I[7:0]};
      asp_pkg::MODE_MONO: tx_pair = {PWDATA_I, PWDATA_I}; // R16
    endcase
  end

  assign tx_wr = wr_acc && PADDR_I == `ASP_TXDATA && tx_cnt != `ASP_PAIRS;
  assign tx_push = tx_wr && (tx_mode != asp_pkg::MODE_DUAL || tx_half);
  assign tx_pop_req = tx_rose && tx_cnt_s == 5'h00 && !is_left(tx_fmt, tx_ws_cur); // R2
  assign tx_pop = tx_pop_req && tx_cnt != 4'h0;
  assign tx_lvl = {tx_cnt, 1'b0} + {4'h0, tx_half}; // R17

  always_ff @(posedge SYS_CLK_I) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= tx_pair;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
      tx_cnt <= 4'h0;
      tx_half <= 1'b0;
      tx_hold <= 32'h0;
    end else begin
      if (tx_wr && tx_mode == asp_pkg::MODE_DUAL) begin
        tx_half <= !tx_half;
        if (!tx_half) begin
          tx_hold <= PWDATA_I;
        end
      end
      if (tx_push) begin
        tx_wp <= tx_wp + 3'h1;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 3'h1;
      end
      if (tx_push && !tx_pop) begin
        tx_cnt <= tx_cnt + 4'h1;
      end else if (tx_pop && !tx_push) begin
        tx_cnt <= tx_cnt - 4'h1;
      end
    end
  end

  // Next bit position is predicted assuming 32-bit slots.
  assign tx_nc = (tx_cnt_s == `ASP_CNT_LAST) ? 5'h00 : tx_cnt_s + 5'h01;
  assign tx_nleft = is_left(tx_fmt, (tx_cnt_s == `ASP_CNT_LAST) ^ tx_ws_cur)
                    ^ (tx_fmt == asp_pkg::FMT_STD && tx_nc == 5'h00);
  assign tx_p = pos_of(tx_nc, tx_fmt, tx_w); // R13
  assign tx_word = tx_nleft ? tx_l : tx_r;

  // Left is loaded at the start of the right slot and right at the start of
  // the left slot, so a trailing LSB is never overwritten before it is sent.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !tx_en) begin
      tx_l <= 32'h0;
      tx_r <= 32'h0;
      tx_pend <= 32'h0;
      TX_SD_O <= 1'b0;
    end else begin
      if (tx_pop_req) begin
        tx_l <= tx_pop ? align(tx_mem[tx_rp][31:0], tx_ss) : 32'h0; // R2
        tx_pend <= tx_pop ? align(tx_mem[tx_rp][63:32], tx_ss) : 32'h0;
      end else if (tx_rose && tx_cnt_s == 5'h00) begin
        tx_r <= tx_pend;
      end
      if (tx_fall) begin
        TX_SD_O <= (tx_p < tx_w) ? tx_word[5'(6'h1F - tx_p)] : 1'b0; // R13
      end
    end
  end

  // --------------------------------------------------------------------
  // Receive deserialiser and FIFO
  // --------------------------------------------------------------------
  logic [2:0] sd_sy;
  logic sd_st;
  logic [63:0] rx_mem [`ASP_PAIRS];
  logic [2:0] rx_wp;
  logic [2:0] rx_rp;
  logic [3:0] rx_cnt;
  logic rx_half;
  logic [31:0] rx_wl;
  logic [31:0] rx_wr;
  logic [31:0] rx_hl;
  logic [31:0] rx_nw;
  logic [5:0] rx_p;
  logic rx_left;
  logic rx_last;
  logic rx_push_req;
  logic rx_armed;
  logic rx_push;
  logic [63:0] rx_pair;
  logic rx_rd;
  logic rx_pop;
  logic [4:0] rx_lvl;
  logic [63:0] rx_head;
  logic [31:0] rx_word;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sd_sy <= 3'h0;
      sd_st <= 1'b0;
    end else begin
      sd_sy <= {sd_sy[1:0], RX_SD_I};
      if (sd_sy[1] == sd_sy[2]) begin
        sd_st <= sd_sy[2];
      end
    end
  end

  assign rx_p = pos_of(rx_cnt_s, rx_fmt, rx_w); // R13
  assign rx_left = is_left(rx_fmt, rx_ws_cur)
                   ^ (rx_fmt == asp_pkg::FMT_STD && rx_cnt_s == 5'h00);
  assign rx_last = rx_rose && rx_en && rx_p == rx_w - 6'h01; // R20

  always_comb begin
    rx_nw = (rx_p == 6'h00) ? 32'h0 : (rx_left ? rx_wl : rx_wr);
    rx_nw[5'(6'h1F - rx_p)] = sd_st;
  end

  // A right word counts only once a left word ended before it, so a
  // stream joined during a right slot never pushes a torn pair.
  assign rx_push_req = rx_last && (rx_left ? rx_mode == asp_pkg::MODE_MONO : rx_armed);
  assign rx_pair = rx_left ? {unalign(rx_nw, rx_ss), unalign(rx_nw, rx_ss)}
                           : {unalign(rx_nw, rx_ss), rx_hl}; // R2
  assign rx_push = rx_push_req && rx_cnt != `ASP_PAIRS;
  assign rx_rd = rd_acc && PADDR_I == `ASP_RXDATA && rx_cnt != 4'h0;
  assign rx_pop = rx_rd && (rx_mode != asp_pkg::MODE_DUAL || rx_half); // R19
  assign rx_lvl = {rx_cnt, 1'b0} - {4'h0, rx_half}; // R17
  assign rx_head = rx_mem[rx_rp];

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !rx_en) begin
      rx_wl <= 32'h0;
      rx_wr <= 32'h0;
      rx_hl <= 32'h0;
      rx_armed <= 1'b0;
    end else if (rx_rose && rx_p < rx_w) begin // R20
      if (rx_left) begin
        rx_wl <= rx_nw;
      end else begin
        rx_wr <= rx_nw;
      end
      if (rx_last && rx_left) begin
        rx_hl <= unalign(rx_nw, rx_ss);
        rx_armed <= 1'b1; // R2
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_pair;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
      rx_cnt <= 4'h0;
      rx_half <= 1'b0;
    end else begin
      if (rx_rd && rx_mode == asp_pkg::MODE_DUAL) begin
        rx_half <= !rx_half; // R19
      end
      if (rx_push) begin
        rx_wp <= rx_wp + 3'h1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 3'h1;
      end
      if (rx_push && !rx_pop) begin
        rx_cnt <= rx_cnt + 4'h1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt <= rx_cnt - 4'h1;
      end
    end
  end

  always_comb begin
    unique case (rx_mode) // R18
      asp_pkg::MODE_DUAL: rx_word = rx_half ? rx_head[63:32] : rx_head[31:0]; // R19
      asp_pkg::MODE_C16: rx_word = {rx_head[47:32], rx_head[15:0]};
      asp_pkg::MODE_C8: rx_word = {16'h0000, rx_head[39:32], rx_head[7:0]};
      asp_pkg::MODE_MONO: rx_word = rx_head[31:0]; // R16
    endcase
    if (rx_cnt == 4'h0) begin
      rx_word = 32'h0;
    end
  end

  // --------------------------------------------------------------------
  // Interrupts, DMA requests and the bus answer
  // --------------------------------------------------------------------
  logic [3:0] set_ev;
  logic [3:0] clr;
  logic tx_req_c;
  logic rx_req_c;

  assign rx_req_c = rx_en && rx_lvl != 5'h00 && rx_lvl >= rx_lim; // R22
  assign tx_req_c = tx_en && tx_lvl <= tx_lim; // R22
  assign set_ev[`ASP_I_RXERR] = rx_push_req && rx_cnt == `ASP_PAIRS; // R21
  assign set_ev[`ASP_I_RXREQ] = rx_req_c; // R3
  assign set_ev[`ASP_I_TXERR] = tx_pop_req && tx_cnt == 4'h0; // R21
  assign set_ev[`ASP_I_TXREQ] = tx_req_c; // R3
  assign clr = (wr_acc && PADDR_I == `ASP_RAWST) ? PWDATA_I[3:0] : 4'h0;

  // A new event outranks a clear landing in the same cycle.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      raw <= 4'h0;
      IRQ_O <= 1'b0;
      TX_DMA_REQ_O <= 1'b0;
      RX_DMA_REQ_O <= 1'b0;
    end else begin
      raw <= (raw & ~clr) | set_ev; // R5 R9
      IRQ_O <= |(raw & int_en); // R6 R7
      TX_DMA_REQ_O <= tx_req_c; // R22
      RX_DMA_REQ_O <= rx_req_c; // R22
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h0;
    case (PADDR_I)
      `ASP_CTRL: rd_data = {28'h0, ctrl};
      `ASP_TXCFG: rd_data = tx_cfg;
      `ASP_RXCFG: rd_data = rx_cfg;
      `ASP_TXDATA: rd_data = 32'h0;
      `ASP_RXDATA: rd_data = rx_word;
      `ASP_TXLVL: rd_data = {27'h0, tx_lvl}; // R4
      `ASP_RXLVL: rd_data = {27'h0, rx_lvl}; // R4
      `ASP_TXLIM: rd_data = {27'h0, tx_lim};
      `ASP_RXLIM: rd_data = {27'h0, rx_lim};
      `ASP_INTEN: rd_data = {28'h0, int_en};
      `ASP_RAWST: rd_data = {28'h0, raw}; // R8
      `ASP_MSKST: rd_data = {28'h0, raw & int_en}; // R8
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: ready rises in the second access cycle.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !mapped;
      if (PSEL_I && PENABLE_I && !PREADY_O) begin
        PRDATA_O <= PWRITE_I ? 32'h0 : rd_data;
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASP_CTRL 8'h00
`define ASP_TXCFG 8'h04
`define ASP_RXCFG 8'h08
`define ASP_TXDATA 8'h0C
`define ASP_RXDATA 8'h10
`define ASP_TXLVL 8'h14
`define ASP_RXLVL 8'h18
`define ASP_TXLIM 8'h1C
`define ASP_RXLIM 8'h20
`define ASP_INTEN 8'h24
`define ASP_RAWST 8'h28
`define ASP_MSKST 8'h2C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASP_TX_EN 0
`define ASP_RX_EN 1
`define ASP_TX_MEXT 2
`define ASP_RX_MEXT 3
`define ASP_CF_FMT 1:0
`define ASP_CF_MST 2
`define ASP_CF_MODE 4:3
`define ASP_CF_SSZ 7:5
`define ASP_CF_WSZ 10:8
`define ASP_CF_DIV 23:16
`define ASP_I_RXERR 0
`define ASP_I_RXREQ 1
`define ASP_I_TXERR 2
`define ASP_I_TXREQ 3

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define ASP_CFG_RST 32'h00030484
`define ASP_CFG_MASK 32'h00FF07FF
`define ASP_LIM_RST 5'h08
`define ASP_PAIRS 4'h8
`define ASP_SLOT 6'h20
`define ASP_CNT_LAST 5'h1F

`endif

// ### hdl/asp_pkg.sv
package asp_pkg;
  typedef enum logic [1:0] {FMT_STD, FMT_LJ, FMT_RJ} asp_fmt_t;
  typedef enum logic [1:0] {MODE_DUAL, MODE_C16, MODE_C8, MODE_MONO} asp_mode_t;
endpackage

// ### hdl/asp_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "asp_map.svh"
module asp_timing (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic master_i,
  input wire logic tick_i,
  input wire logic [7:0] div_i,
  input wire logic sclk_pin_i,
  input wire logic ws_pin_i,
  output logic sclk_o,
  output logic ws_o,
  output logic rise_o,
  output logic fall_o,
  output logic [4:0] cnt_o,
  output logic ws_cur_o
);
  logic [2:0] sclk_sy;
  logic [2:0] ws_sy;
  logic sclk_st;
  logic ws_st;
  logic [7:0] dcnt;
  logic m_flip;
  logic ws_now;

  assign m_flip = tick_i && (dcnt == div_i);

  always_comb begin
    if (master_i) begin
      rise_o = en_i && m_flip && !sclk_o;
      fall_o = en_i && m_flip && sclk_o;
      ws_now = ws_o;
    end else begin
      rise_o = en_i && (sclk_sy[1] == sclk_sy[2]) && sclk_sy[2] && !sclk_st;
      fall_o = en_i && (sclk_sy[1] == sclk_sy[2]) && !sclk_sy[2] && sclk_st;
      ws_now = ws_st;
    end
  end

  // A pin level counts once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_sy <= 3'h0;
      ws_sy <= 3'h0;
      sclk_st <= 1'b0;
      ws_st <= 1'b0;
    end else begin
      sclk_sy <= {sclk_sy[1:0], sclk_pin_i};
      ws_sy <= {ws_sy[1:0], ws_pin_i};
      if (sclk_sy[1] == sclk_sy[2]) begin
        sclk_st <= sclk_sy[2];
      end
      if (ws_sy[1] == ws_sy[2]) begin
        ws_st <= ws_sy[2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i || !master_i) begin
      dcnt <= 8'h00;
      sclk_o <= 1'b0;
    end else if (tick_i) begin
      if (m_flip) begin
        dcnt <= 8'h00;
        sclk_o <= !sclk_o; // R10
      end else begin
        dcnt <= dcnt + 8'h01;
      end
    end
  end

  // Word clock changes on the falling edge that ends a 32-bit slot.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i || !master_i) begin
      ws_o <= 1'b0;
    end else if (fall_o && cnt_o == `ASP_CNT_LAST) begin
      ws_o <= !ws_o; // R14
    end
  end

  // While idle the word clock is tracked, so the first change after enable
  // starts a fresh slot instead of being taken for the middle of one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o <= 5'h00;
      ws_cur_o <= 1'b0;
    end else if (!en_i) begin
      cnt_o <= 5'h00;
      ws_cur_o <= ws_now;
    end else if (rise_o) begin
      if (ws_now != ws_cur_o) begin
        cnt_o <= 5'h00;
      end else if (cnt_o != `ASP_CNT_LAST) begin
        cnt_o <= cnt_o + 5'h01;
      end
      ws_cur_o <= ws_now;
    end
  end
endmodule
`default_nettype wire

// ### tb/asp_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
module asp_port_chk (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TX_SCLK_OE_O,
  input wire logic TX_WS_OE_O,
  input wire logic TX_SCLK_O,
  input wire logic TX_WS_O
);
  logic acc;
  logic rd;
  assign acc = PSEL_I && PENABLE_I && PREADY_O;
  assign rd = acc && !PWRITE_I;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  chk_ready_wait: assert property (PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O)
    else $error("late ready");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("long ready");
  chk_err_hole: assert property (acc && PADDR_I > 8'h2C |-> PSLVERR_O && PRDATA_O == 0)
    else $error("no error");
  chk_err_none: assert property (acc && PADDR_I < 8'h2D && PADDR_I[1:0] == 0 |-> !PSLVERR_O)
    else $error("false error");
  chk_write_zero: assert property (acc && PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("write data out");
  chk_lvl_span: assert property (rd && PADDR_I inside {8'h14, 8'h18} |-> PRDATA_O < 32'h11)
    else $error("level range");
  chk_stat_bits: assert property (rd && PADDR_I[7:3] == 5'h05 |-> PRDATA_O[31:4] == 0)
    else $error("status bits");
  chk_tx_oe_pair: assert property (TX_SCLK_OE_O == TX_WS_OE_O)
    else $error("oe split");
  chk_clk_quiet: assert property (!TX_SCLK_OE_O |-> !TX_SCLK_O && !TX_WS_O)
    else $error("clock driven while released");
  cover property (acc && PSLVERR_O);
  cover property (rd && PADDR_I == 8'h10);
  cover property ($rose(TX_SCLK_OE_O));
endmodule
bind asp_port asp_port_chk u_chk (.SYS_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .TX_SCLK_OE_O, .TX_WS_OE_O, .TX_SCLK_O,
  .TX_WS_O);
`default_nettype wire

// ### tb/asp_codec.sv
`timescale 1ns/100ps
`default_nettype none
module asp_codec (
  input wire logic go_i,
  input wire logic [63:0] pair_i,
  output logic sclk_o,
  output logic ws_o,
  output logic sd_o
);
  int k;
  initial begin
    sclk_o = 1'b0;
    ws_o = 1'b1;
    sd_o = 1'b0;
  end
  // The codec owns the clocks; the bit clock stands still between bursts.
  always @(posedge go_i) begin
    for (k = 0; k < 129; k++) begin
      ws_o = (k % 64) >= 32;
      sd_o = pair_i[63 - ((k + 63) % 64)];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    sd_o = ~sd_o;
    ws_o = 1'b1;
  end
endmodule
`default_nettype wire

// ### tb/asp_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module asp_port_tb_top;
  localparam logic [31:0] LS = 32'hA5C30F81;
  localparam logic [31:0] RS = 32'h3C5AF018;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic en = 1'b0;
  logic wr = 1'b0;
  logic go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, r;
  logic rdy, serr, err, irq, txdma, rxdma, sck, ws, sd;
  logic tsck, tws, tsd;
  logic tsck_q = 1'b0;
  logic tws_q = 1'b0;
  logic [31:0] tsh, tcap;
  int tws_n = 0;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  asp_codec u_codec (.go_i(go), .pair_i({LS, RS}), .sclk_o(sck), .ws_o(ws), .sd_o(sd));
  asp_port u_dut (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(sel), .PENABLE_I(en),
    .PWRITE_I(wr), .PADDR_I(adr), .PWDATA_I(wd), .PRDATA_O(rdat), .PREADY_O(rdy),
    .PSLVERR_O(serr), .MCLK_EXT_I(1'b0), .TX_SCLK_I(1'b0), .TX_SCLK_O(tsck), .TX_SCLK_OE_O(),
    .TX_WS_I(1'b0), .TX_WS_O(tws), .TX_WS_OE_O(), .TX_SD_O(tsd), .RX_SCLK_I(sck), .RX_SCLK_O(),
    .RX_SCLK_OE_O(), .RX_WS_I(ws), .RX_WS_O(), .RX_WS_OE_O(), .RX_SD_I(sd), .IRQ_O(irq),
    .TX_DMA_REQ_O(txdma), .RX_DMA_REQ_O(rxdma));
  // Transmit bits are taken at each rising bit clock; the word that ends at the
  // second rise of the word clock is the first left sample sent.
  always @(posedge clk) begin
    tsck_q <= tsck;
    if (tsck && !tsck_q) begin
      tsh <= {tsh[30:0], tsd};
      tws_q <= tws;
      if (tws && !tws_q) begin
        tws_n <= tws_n + 1;
        if (tws_n == 1) begin
          tcap <= {tsh[30:0], tsd};
        end
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
    err = serr;
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
  endtask
  // One burst is two frames plus a bit; the margin covers pin sync and the push.
  task automatic run();
    go <= 1'b1;
    repeat (1060) @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic t_regs();
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 32'h00030484);
    bus(1'b0, 8'h20, 32'h0);
    chk(r, 32'h8);
    bus(1'b1, 8'h40, 32'h1);
    chk(32'(err), 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_tx_level();
    bus(1'b1, 8'h0C, LS);
    bus(1'b0, 8'h14, 32'h0);
    chk(r, 32'h1);
    bus(1'b1, 8'h0C, RS);
    bus(1'b0, 8'h14, 32'h0);
    chk(r, 32'h2);
    chk(32'(txdma), 32'h0);
    $display("t_tx_level done");
  endtask
  task automatic t_rx();
    bus(1'b1, 8'h08, 32'h00030480);
    run();
    bus(1'b0, 8'h18, 32'h0);
    chk(r, 32'h0);
    bus(1'b1, 8'h20, 32'h4);
    bus(1'b1, 8'h00, 32'h2);
    run();
    bus(1'b0, 8'h18, 32'h0);
    chk(r, 32'h4);
    chk(32'(rxdma), 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    chk(r, LS);
    bus(1'b0, 8'h18, 32'h0);
    chk(r, 32'h3);
    chk(32'(rxdma), 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(r, RS);
    $display("t_rx done");
  endtask
  task automatic t_irq();
    bus(1'b1, 8'h00, 32'h1);
    repeat (2000) @(posedge clk);
    chk(tcap, LS);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h28, 32'h0);
    chk(r & 32'h4, 32'h4);
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b0, 8'h2C, 32'h0);
    chk(r, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b1, 8'h24, 32'h4);
    bus(1'b0, 8'h2C, 32'h0);
    chk(r, 32'h4);
    chk(32'(irq), 32'h1);
    bus(1'b1, 8'h28, 32'h4);
    bus(1'b0, 8'h28, 32'h0);
    chk(r & 32'h4, 32'h0);
    chk(32'(irq), 32'h0);
    $display("t_irq done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 12000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx_level();
    t_rx();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
